// file: common/cecr_defines.vh
/*
  Constants for the copier error code reporter: display codes, LED patterns,
  and timing figures. Assumes a 100 MHz system clock.
*/
`ifndef CECR_DEFINES_VH
`define CECR_DEFINES_VH

// Seven-segment code values (low nibble), with the decimal point kept apart.
`define CECR_ST_ROM0        4'h0
`define CECR_ST_ROM1        4'h1
`define CECR_ST_RAM_CLR     4'h2
`define CECR_ST_RAM_SET     4'h3
`define CECR_ST_INT65       4'h4
`define CECR_ST_PORT_CHIP   4'h5
`define CECR_ST_TIMER_CHIP  4'h6
`define CECR_ST_BUFA_CLR    4'h7
`define CECR_ST_BUFA_INC    4'h8
`define CECR_ST_INT_CMD     4'hA
`define CECR_ST_INT_DATA    4'hB
`define CECR_ST_BUFB_CLR    4'hC
`define CECR_ST_BUFB_INC    4'hD
`define CECR_ST_BUFA_CMP    4'hE
`define CECR_ST_BUFB_CMP    4'hF

`define CECR_OP_WASH        4'h0
`define CECR_OP_NO_READY    4'h1
`define CECR_OP_PAPER_INK   4'h2
`define CECR_OP_BAD_CMD     4'h3
`define CECR_OP_SHORT_REQ   4'h4
`define CECR_OP_CHECKSUM    4'h5
`define CECR_OP_BAD_PARAM   4'h6
`define CECR_OP_NO_XFER     4'h7
`define CECR_OP_SLEW_TMO    4'h8
`define CECR_OP_UNLOAD      4'h9
`define CECR_OP_LINE_COUNT  4'hA
`define CECR_OP_PIX_GIVEUP  4'hB
`define CECR_OP_PIX_RETRY   4'hC
`define CECR_OP_CMD_TMO     4'hD
`define CECR_OP_ABORT       4'hE

// Pixel-count errors that still earn a retransmit request.
`define CECR_PIX_RETRY_MAX  3'h4

// Five-LED mechanism codes, a lit LED is a one.
`define CECR_LED_NORMAL     5'h1F
`define CECR_LED_CARR_MOVE  5'h05
`define CECR_LED_CARR_HOME  5'h06
`define CECR_LED_ENCODER    5'h09
`define CECR_LED_DRUM_ROT   5'h0A
`define CECR_LED_CAR_REAR   5'h0D
`define CECR_LED_CAR_FWD    5'h0E
`define CECR_LED_UNLOAD_ROL 5'h0C
`define CECR_LED_DRUM_LOCK  5'h16
`define CECR_LED_DRUM_SYNC  5'h0F
`define CECR_LED_SENSOR     5'h18
`define CECR_LED_BOARD_FAIL 5'h00

// Timing figures and their cycle counts at 100 MHz.
`define CECR_CLK_MHZ        100
`define CECR_INIT_LIMIT_S   20
`define CECR_INIT_CYCLES    (`CECR_INIT_LIMIT_S * `CECR_CLK_MHZ * 1000000)
`define CECR_IDLE_LIMIT_MIN 11
`define CECR_IDLE_CYCLES    (`CECR_IDLE_LIMIT_MIN * 40'h3C * `CECR_CLK_MHZ * 40'hF4240)
`define CECR_FLASH_MS       250
`define CECR_FLASH_CYCLES   (`CECR_FLASH_MS * `CECR_CLK_MHZ * 1000)

`endif

// file: rtl/cecr_reporter.v
/*
  Error code reporter of the copier interface board and mechanism controller.
  Encodes self-test failures, host protocol faults and mechanism faults onto a
  seven-segment display with decimal point, an indicator LED and five LEDs.
  Assumes all event inputs are one-cycle pulses from logic on clk; the level
  inputs from the mechanism come from pins and are synchronised here.
*/
// Contract
// (RULE_01) Self-test shows .0 or .1 for a failed program memory checksum.
// (RULE_02) Self-test shows .2 when scratch RAM will not clear, .3 when not set.
// (RULE_03) Line buffer A counter clear failure shows .7, increment failure .8.
// (RULE_04) Medium interrupt failure shows .A on command path, .b on data path.
// (RULE_05) Wash cycle shows 0, then restores the previous code.
// (RULE_06) Missing mechanism ready signal shows code 1.
// (RULE_07) Unrecognised or out-of-sequence command is rejected, shows 3.
// (RULE_08) Short or early-terminated print request is rejected, shows 4.
// (RULE_09) Print request checksum mismatch is rejected, shows 5.
// (RULE_10) Illegal or out-of-range print parameters are rejected, shows 6.
// (RULE_11) Missing transfer ready aborts the copy, shows 7.
// (RULE_12) Fast slew handshake timeout aborts the copy, shows 8.
// (RULE_13) Failed paper unload sequence is fatal, shows 9.
// (RULE_14) Line terminator count differing from expected at transmission end shows A.
// (RULE_15) Each of up to four pixel-count errors requests retransmit, shows C.
// (RULE_16) Beyond four pixel-count errors, no retransmit, print held data, show b.
// (RULE_17) No valid command for eleven minutes aborts the copy, shows d.
// (RULE_18) Host abort command ends the copy, shows E.
// (RULE_19) Five LEDs: all on is normal, undefined patterns mean board failure.
// (RULE_20) Carriage not moving shows 00101, not returning home 00110.
// (RULE_21) Encoder pulses missing 01001, drum rotation 01010, drum lock 10110.
// (RULE_22) Bad sensor 11000, carrier not rear 01101, not forward 01110.
// (RULE_23) Indicator flashes during init, steady on success; after twenty seconds, failure.
// (RULE_24) Blank display with steady indicator is normal; codes held until power-off.
// (RULE_25) A new operational error replaces the code on display.
`timescale 1ns/1ps
`default_nettype none
`include "cecr_defines.vh"

module cecr_reporter #(
  parameter [31:0] INIT_CYCLES  = `CECR_INIT_CYCLES,
  parameter [39:0] IDLE_CYCLES  = `CECR_IDLE_CYCLES,
  parameter [31:0] FLASH_CYCLES = `CECR_FLASH_CYCLES,
  parameter        LINE_W       = 16
) (
  input  wire              clk,
  input  wire              rst_b,
  input  wire              selftest_done,
  input  wire [14:0]       selftest_fail,
  input  wire              wash_active,
  input  wire              mech_ctrl_ready,
  input  wire              ready_timeout,
  input  wire              cmd_valid,
  input  wire              cmd_unknown,
  input  wire              cmd_out_of_seq,
  input  wire              cmd_abort,
  input  wire              req_short,
  input  wire              req_checksum_bad,
  input  wire              req_param_bad,
  input  wire              copy_active,
  input  wire              xfer_ready_timeout,
  input  wire              slew_timeout,
  input  wire              unload_fail,
  input  wire              line_terminator,
  input  wire              transmission_end,
  input  wire [LINE_W-1:0] lines_expected,
  input  wire              pixel_count_bad,
  input  wire              copy_start,
  input  wire [10:0]       mech_fault,
  output wire              cmd_reject,
  output reg               copy_abort,
  output reg               fatal_stop,
  output reg               retransmit_req,
  output reg               print_held_data,
  output reg  [3:0]        seg_code,
  output reg               seg_point,
  output reg               seg_blank,
  output reg               indicator_led,
  output reg  [4:0]        mech_leds
);

  ////////////////////////////////////////////////////////////////////////////
  // One-hot init states.
  localparam [2:0] S_INIT = 3'b001;
  localparam [2:0] S_RUN  = 3'b010;
  localparam [2:0] S_FAIL = 3'b100;

  // Decimal code for each self-test failure bit, lowest bit wins.
  function [3:0] st_code;
    input [14:0] f;
    begin
      if (f[0]) st_code = `CECR_ST_ROM0;                // [RULE_01]
      else if (f[1]) st_code = `CECR_ST_ROM1;           // [RULE_01]
      else if (f[2]) st_code = `CECR_ST_RAM_CLR;        // [RULE_02]
      else if (f[3]) st_code = `CECR_ST_RAM_SET;        // [RULE_02]
      else if (f[4]) st_code = `CECR_ST_INT65;
      else if (f[5]) st_code = `CECR_ST_PORT_CHIP;
      else if (f[6]) st_code = `CECR_ST_TIMER_CHIP;
      else if (f[7]) st_code = `CECR_ST_BUFA_CLR;       // [RULE_03]
      else if (f[8]) st_code = `CECR_ST_BUFA_INC;       // [RULE_03]
      else if (f[9]) st_code = `CECR_ST_INT_CMD;        // [RULE_04]
      else if (f[10]) st_code = `CECR_ST_INT_DATA;      // [RULE_04]
      else if (f[11]) st_code = `CECR_ST_BUFB_CLR;
      else if (f[12]) st_code = `CECR_ST_BUFB_INC;
      else if (f[13]) st_code = `CECR_ST_BUFA_CMP;
      else st_code = `CECR_ST_BUFB_CMP;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Synchronisers for pin-level mechanism inputs.
  reg [11:0] sync1_reg;
  reg [11:0] sync2_reg;

  always @(posedge clk) begin
    if (!rst_b) begin
      sync1_reg <= 12'h000;
      sync2_reg <= 12'h000;
    end else begin
      sync1_reg <= {mech_ctrl_ready, mech_fault};
      sync2_reg <= sync1_reg;
    end
  end

  wire        ready_s = sync2_reg[11];
  wire [10:0] fault_s = sync2_reg[10:0];

  ////////////////////////////////////////////////////////////////////////////
  // Initialisation sequence and indicator LED.
  reg [2:0]  state_reg;
  reg [31:0] init_cnt_reg;
  reg [31:0] flash_cnt_reg;
  reg        flash_reg;
  reg        st_point_reg;
  reg [3:0]  st_code_reg;

  // Divider pulse that paces the indicator flash.
  wire       flash_tick = (flash_cnt_reg >= FLASH_CYCLES - 32'h1);

  always @(posedge clk) begin
    if (!rst_b) begin
      state_reg     <= S_INIT;
      init_cnt_reg  <= 32'h0;
      flash_cnt_reg <= 32'h0;
      flash_reg     <= 1'b0;
      st_point_reg  <= 1'b0;
      st_code_reg   <= 4'h0;
    end else begin
      if (flash_tick) begin
        flash_cnt_reg <= 32'h0;
        flash_reg     <= ~flash_reg;
      end else begin
        flash_cnt_reg <= flash_cnt_reg + 32'h1;
      end
      case (state_reg)
        S_INIT: begin
          if (init_cnt_reg < INIT_CYCLES) begin
            init_cnt_reg <= init_cnt_reg + 32'h1;
          end
          if (selftest_done && selftest_fail != 15'h0000) begin
            state_reg    <= S_FAIL;                     // [RULE_23]
            st_point_reg <= 1'b1;
            st_code_reg  <= st_code(selftest_fail);
          end else if (selftest_done) begin
            state_reg <= S_RUN;                         // [RULE_23]
          end else if (init_cnt_reg >= INIT_CYCLES - 32'h1) begin
            state_reg    <= S_FAIL;                     // [RULE_23]
            st_point_reg <= 1'b1;
            st_code_reg  <= `CECR_ST_INT65;
          end
        end
        S_RUN: begin
          state_reg <= S_RUN;
        end
        S_FAIL: begin
          state_reg <= S_FAIL;
        end
        default: begin
          state_reg <= S_INIT;
        end
      endcase
    end
  end

  wire running = (state_reg == S_RUN);

  ////////////////////////////////////////////////////////////////////////////
  // Copy tracking: line count, pixel errors, command watchdog.
  reg [LINE_W-1:0] line_cnt_reg;
  reg [2:0]        pix_err_reg;
  reg [39:0]       idle_cnt_reg;

  wire pix_retry   = pixel_count_bad && running && (pix_err_reg < `CECR_PIX_RETRY_MAX);
  wire pix_giveup  = pixel_count_bad && running && (pix_err_reg >= `CECR_PIX_RETRY_MAX);
  wire lines_wrong = transmission_end && (line_cnt_reg != lines_expected);
  wire idle_expire = copy_active && (idle_cnt_reg >= IDLE_CYCLES - 40'h1);

  assign cmd_reject = running && (cmd_unknown || cmd_out_of_seq ||          // [RULE_07]
                                  req_short || req_checksum_bad || req_param_bad);

  always @(posedge clk) begin
    if (!rst_b) begin
      line_cnt_reg    <= {LINE_W{1'b0}};
      pix_err_reg     <= 3'h0;
      idle_cnt_reg    <= 40'h0;
      retransmit_req  <= 1'b0;
      print_held_data <= 1'b0;
      copy_abort      <= 1'b0;
      fatal_stop      <= 1'b0;
    end else begin
      retransmit_req <= pix_retry;                      // [RULE_15]
      copy_abort     <= running && (xfer_ready_timeout || slew_timeout ||   // [RULE_11] [RULE_12]
                                    idle_expire || cmd_abort);              // [RULE_17] [RULE_18]
      if (running && unload_fail) begin
        fatal_stop <= 1'b1;                             // [RULE_13]
      end
      if (copy_start) begin
        line_cnt_reg    <= {LINE_W{1'b0}};
        pix_err_reg     <= 3'h0;
        print_held_data <= 1'b0;
      end else begin
        if (line_terminator) begin
          line_cnt_reg <= line_cnt_reg + {{(LINE_W-1){1'b0}}, 1'b1};        // [RULE_14]
        end
        if (pixel_count_bad && running && pix_err_reg <= `CECR_PIX_RETRY_MAX) begin
          pix_err_reg <= pix_err_reg + 3'h1;
        end
      end
      if (pix_giveup) begin
        print_held_data <= 1'b1;                        // [RULE_16]
      end
      if (cmd_valid || !copy_active || idle_expire) begin
        idle_cnt_reg <= 40'h0;
      end else begin
        idle_cnt_reg <= idle_cnt_reg + 40'h1;           // [RULE_17]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Operational code register; newest event replaces the held code.
  reg       op_valid_reg;
  reg [3:0] op_code_reg;
  reg       op_valid_next;
  reg [3:0] op_code_next;

  always @* begin
    op_valid_next = 1'b1;
    op_code_next  = op_code_reg;
    if (cmd_abort) begin
      op_code_next = `CECR_OP_ABORT;                    // [RULE_18]
    end else if (idle_expire) begin
      op_code_next = `CECR_OP_CMD_TMO;                  // [RULE_17]
    end else if (pix_retry) begin
      op_code_next = `CECR_OP_PIX_RETRY;                // [RULE_15]
    end else if (pix_giveup) begin
      op_code_next = `CECR_OP_PIX_GIVEUP;               // [RULE_16]
    end else if (lines_wrong) begin
      op_code_next = `CECR_OP_LINE_COUNT;               // [RULE_14]
    end else if (unload_fail) begin
      op_code_next = `CECR_OP_UNLOAD;                   // [RULE_13]
    end else if (slew_timeout) begin
      op_code_next = `CECR_OP_SLEW_TMO;                 // [RULE_12]
    end else if (xfer_ready_timeout) begin
      op_code_next = `CECR_OP_NO_XFER;                  // [RULE_11]
    end else if (req_param_bad) begin
      op_code_next = `CECR_OP_BAD_PARAM;                // [RULE_10]
    end else if (req_checksum_bad) begin
      op_code_next = `CECR_OP_CHECKSUM;                 // [RULE_09]
    end else if (req_short) begin
      op_code_next = `CECR_OP_SHORT_REQ;                // [RULE_08]
    end else if (cmd_unknown || cmd_out_of_seq) begin
      op_code_next = `CECR_OP_BAD_CMD;                  // [RULE_07]
    end else if (ready_timeout && !ready_s) begin
      op_code_next = `CECR_OP_NO_READY;                 // [RULE_06]
    end else begin
      op_valid_next = op_valid_reg;
    end
  end

  always @(posedge clk) begin
    if (!rst_b) begin
      op_valid_reg <= 1'b0;
      op_code_reg  <= 4'h0;
    end else if (running) begin
      op_valid_reg <= op_valid_next;                    // [RULE_25] [RULE_24]
      op_code_reg  <= op_code_next;                     // [RULE_25]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Display and LED drivers.
  always @(posedge clk) begin
    if (!rst_b) begin
      seg_code      <= 4'h0;
      seg_point     <= 1'b0;
      seg_blank     <= 1'b1;
      indicator_led <= 1'b0;
    end else begin
      indicator_led <= running ? 1'b1 : flash_reg;      // [RULE_23]
      if (state_reg == S_FAIL) begin
        seg_code  <= st_code_reg;                       // [RULE_01] [RULE_02] [RULE_03] [RULE_04]
        seg_point <= st_point_reg;
        seg_blank <= 1'b0;
      end else if (running && wash_active) begin
        seg_code  <= `CECR_OP_WASH;                     // [RULE_05]
        seg_point <= 1'b0;
        seg_blank <= 1'b0;
      end else begin
        seg_code  <= op_code_reg;                       // [RULE_05] [RULE_24]
        seg_point <= 1'b0;
        seg_blank <= ~(running && op_valid_reg);        // [RULE_24]
      end
    end
  end

  always @(posedge clk) begin
    if (!rst_b) begin
      mech_leds <= `CECR_LED_NORMAL;
    end else if (fault_s[0]) begin
      mech_leds <= `CECR_LED_CARR_MOVE;                 // [RULE_20]
    end else if (fault_s[1]) begin
      mech_leds <= `CECR_LED_CARR_HOME;                 // [RULE_20]
    end else if (fault_s[2]) begin
      mech_leds <= `CECR_LED_ENCODER;                   // [RULE_21]
    end else if (fault_s[3]) begin
      mech_leds <= `CECR_LED_DRUM_ROT;                  // [RULE_21]
    end else if (fault_s[4]) begin
      mech_leds <= `CECR_LED_DRUM_LOCK;                 // [RULE_21]
    end else if (fault_s[5]) begin
      mech_leds <= `CECR_LED_SENSOR;                    // [RULE_22]
    end else if (fault_s[6]) begin
      mech_leds <= `CECR_LED_CAR_REAR;                  // [RULE_22]
    end else if (fault_s[7]) begin
      mech_leds <= `CECR_LED_CAR_FWD;                   // [RULE_22]
    end else if (fault_s[8]) begin
      mech_leds <= `CECR_LED_UNLOAD_ROL;
    end else if (fault_s[9]) begin
      mech_leds <= `CECR_LED_DRUM_SYNC;
    end else if (fault_s[10]) begin
      mech_leds <= `CECR_LED_BOARD_FAIL;                // [RULE_19]
    end else begin
      mech_leds <= `CECR_LED_NORMAL;                    // [RULE_19]
    end
  end

endmodule
`default_nettype wire

// file: tb/cecr_monitor.sv
/*
  Checker for the error code reporter: ties display codes and pulses to their causes.
  Assumes it is bound to cecr_reporter and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none
module cecr_monitor (
  input wire logic        clk, rst_b, selftest_done, wash_active, cmd_unknown, cmd_out_of_seq,
  input wire logic        cmd_abort, req_short, req_checksum_bad, req_param_bad, pixel_count_bad,
  input wire logic        unload_fail, cmd_reject, copy_abort, fatal_stop, retransmit_req,
  input wire logic        print_held_data, seg_point, seg_blank,
  input wire logic [10:0] mech_fault,
  input wire logic [3:0]  seg_code,
  input wire logic [4:0]  mech_leds
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  a_reject_cause:
    assert property (cmd_reject |-> (cmd_unknown | cmd_out_of_seq | req_short | req_checksum_bad | req_param_bad))
    else $error("reject without a cause");
  a_abort_code:
    assert property (copy_abort && $past(cmd_abort) |=> seg_code == 4'hE && !seg_blank)
    else $error("abort code not shown");
  a_retx_code:
    assert property (retransmit_req |-> $past(pixel_count_bad) ##1 (seg_code == 4'hC))
    else $error("retransmit without pixel error or code");
  a_held_quiet:
    assert property ($rose(print_held_data) |-> !retransmit_req && $past(pixel_count_bad))
    else $error("held data with retransmit");
  a_fatal_hold:
    assert property ($rose(fatal_stop) |-> $past(unload_fail) ##1 (fatal_stop && seg_code == 4'h9) [*3])
    else $error("fatal stop not held");
  a_wash_zero:
    assert property (wash_active && $past(wash_active) |-> seg_code == 4'h0 && !seg_blank && !seg_point)
    else $error("wash code not shown");
  a_point_cause:
    assert property ($rose(seg_point) |-> $past(selftest_done, 2))
    else $error("point without self-test end");
  a_mech_normal:
    assert property ((mech_fault == 11'h000) [*4] |-> mech_leds == 5'h1F)
    else $error("normal pattern missing");
endmodule
bind cecr_reporter cecr_monitor mon (.clk(clk), .rst_b(rst_b), .selftest_done(selftest_done),
  .wash_active(wash_active), .cmd_unknown(cmd_unknown), .cmd_out_of_seq(cmd_out_of_seq), .cmd_abort(cmd_abort),
  .req_short(req_short), .req_checksum_bad(req_checksum_bad), .req_param_bad(req_param_bad),
  .pixel_count_bad(pixel_count_bad), .unload_fail(unload_fail), .cmd_reject(cmd_reject),
  .copy_abort(copy_abort), .fatal_stop(fatal_stop), .retransmit_req(retransmit_req),
  .print_held_data(print_held_data), .seg_point(seg_point), .seg_blank(seg_blank),
  .mech_fault(mech_fault), .seg_code(seg_code), .mech_leds(mech_leds));
`default_nettype wire

// file: tb/cecr_host.sv
/*
  Host model: raises one-cycle command and data event pulses and line terminators.
  Assumes the bench calls its tasks on falling clock edges.
*/
`timescale 1ns/1ps
`default_nettype none
module cecr_host (
  input  wire logic        clk,
  output wire logic        cmd_valid, cmd_unknown, cmd_out_of_seq, cmd_abort,
  output wire logic        req_short, req_checksum_bad, req_param_bad,
  output wire logic        line_terminator, transmission_end, pixel_count_bad, copy_start,
  output var  logic [15:0] lines_expected
);
  logic [10:0] ev;
  assign {copy_start, pixel_count_bad, transmission_end, line_terminator, req_param_bad, req_checksum_bad,
          req_short, cmd_abort, cmd_out_of_seq, cmd_unknown, cmd_valid} = ev;
  initial begin
    ev = 11'h000;
    lines_expected = 16'h0002;
  end
  task hit(input int k);
    ev[k] = 1'b1;
  endtask
  task clr;
    ev = 11'h000;
  endtask
  // Sends n lines, each closed by a terminator pulse.
  task send_lines(input int n);
    repeat (n) begin
      @(negedge clk);
      ev[7] = 1'b1;
      @(negedge clk);
      ev[7] = 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// file: tb/cecr_reporter_tb.sv
/*
  Bench for the error code reporter: queues expected display words and compares them on change.
  Assumes the host model cecr_host and a 100 MHz clock.
*/
`timescale 1ns/1ps
`default_nettype none
module cecr_reporter_tb;
  logic clk, rst_b, selftest_done, wash_active, mech_ctrl_ready, copy_active;
  logic [14:0] selftest_fail;
  logic [10:0] mech_fault;
  logic [3:0]  tev;
  logic [5:0]  q[$];
  logic [5:0]  last;
  wire cmd_valid, cmd_unknown, cmd_out_of_seq, cmd_abort, req_short, req_checksum_bad, req_param_bad;
  wire line_terminator, transmission_end, pixel_count_bad, copy_start, cmd_reject, copy_abort, fatal_stop;
  wire retransmit_req, print_held_data, seg_point, seg_blank, indicator_led;
  wire [15:0] lines_expected;
  wire [3:0]  seg_code;
  wire [4:0]  mech_leds;
  wire [5:0]  disp = {seg_blank, seg_point, seg_code};
  int n_fail, tests_run, cyc, i, b, n;
  int stb[8] = '{0, 1, 2, 3, 7, 8, 9, 10};
  int ek[7] = '{1, 4, 2, 5, 6, 12, 13};
  logic [3:0] ec[7] = '{4'h3, 4'h4, 4'h3, 4'h5, 4'h6, 4'h7, 4'h8};
  logic [4:0] ml[11] = '{5'h05, 5'h06, 5'h09, 5'h0A, 5'h16, 5'h18, 5'h0D, 5'h0E, 5'h0C, 5'h0F, 5'h00};
  cecr_reporter #(.INIT_CYCLES(32'h000000C8), .IDLE_CYCLES(40'h000000012C), .FLASH_CYCLES(32'h00000004)) uut (
    .clk(clk), .rst_b(rst_b), .selftest_done(selftest_done), .selftest_fail(selftest_fail),
    .wash_active(wash_active), .mech_ctrl_ready(mech_ctrl_ready), .ready_timeout(tev[0]),
    .cmd_valid(cmd_valid), .cmd_unknown(cmd_unknown), .cmd_out_of_seq(cmd_out_of_seq), .cmd_abort(cmd_abort),
    .req_short(req_short), .req_checksum_bad(req_checksum_bad), .req_param_bad(req_param_bad),
    .copy_active(copy_active), .xfer_ready_timeout(tev[1]), .slew_timeout(tev[2]), .unload_fail(tev[3]),
    .line_terminator(line_terminator), .transmission_end(transmission_end), .lines_expected(lines_expected),
    .pixel_count_bad(pixel_count_bad), .copy_start(copy_start), .mech_fault(mech_fault),
    .cmd_reject(cmd_reject), .copy_abort(copy_abort), .fatal_stop(fatal_stop), .retransmit_req(retransmit_req),
    .print_held_data(print_held_data), .seg_code(seg_code), .seg_point(seg_point), .seg_blank(seg_blank),
    .indicator_led(indicator_led), .mech_leds(mech_leds));
  cecr_host host (.clk(clk), .cmd_valid(cmd_valid), .cmd_unknown(cmd_unknown), .cmd_out_of_seq(cmd_out_of_seq),
    .cmd_abort(cmd_abort), .req_short(req_short), .req_checksum_bad(req_checksum_bad),
    .req_param_bad(req_param_bad), .line_terminator(line_terminator), .transmission_end(transmission_end),
    .pixel_count_bad(pixel_count_bad), .copy_start(copy_start), .lines_expected(lines_expected));
  ////////////////////////////////////////////////////////////////////////////////
  task check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task give_verdict;
    if (n_fail == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task do_reset;
    @(negedge clk);
    rst_b = 1'b0;
    repeat (3) @(negedge clk);
    rst_b = 1'b1;
  endtask
  task st(input logic [14:0] f, input logic [5:0] note);
    @(negedge clk);
    selftest_fail = f;
    selftest_done = 1'b1;
    if (f != 15'h0000) q.push_back(note);
    @(negedge clk);
    selftest_done = 1'b0;
  endtask
  // Pulses one event, checks reject and abort, then queues the code it should show.
  task ev(input int k, input logic [3:0] code, input logic rej, input logic abt);
    @(negedge clk);
    if (k < 11) host.hit(k);
    else tev[k-11] = 1'b1;
    #2 check(cmd_reject, rej);
    @(posedge clk) #1 check(copy_abort, abt);
    @(negedge clk);
    host.clr();
    tev = 4'h0;
    if (code != 4'hF) q.push_back({2'b00, code});
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    #1;
    if (rst_b && disp !== last) check(disp, q.size() ? q.pop_front() : 6'h3F);
    last = disp;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 4000) begin
      n_fail++;
      give_verdict();
    end
  end
  initial begin
    rst_b = 1'b0; selftest_done = 1'b0; selftest_fail = 15'h0000; wash_active = 1'b0;
    mech_ctrl_ready = 1'b1; copy_active = 1'b0; mech_fault = 11'h000; tev = 4'h0;
    n = $urandom(32'h3894);
    repeat (12) @(negedge clk);
    rst_b = 1'b1;
    foreach (stb[j]) begin
      do_reset();
      b = stb[j];
      st((15'h0001 << b) | (15'($urandom) << (b + 1)), {2'b01, b < 9 ? 4'(b) : 4'(b + 1)});
      repeat (3) begin
        @(negedge clk);
        tev = 4'($urandom);
        mech_ctrl_ready = 1'($urandom);
        copy_active = 1'($urandom);
      end
      check({fatal_stop, copy_abort, retransmit_req}, 0);
    end
    ev(3, 4'hF, 0, 0);
    do_reset();
    st(15'h0000, 6'h00);
    repeat (8) begin
      @(negedge clk);
      check(indicator_led, 1);
    end
    check(seg_blank, 1);
    copy_active = 1'b1;
    ev(0, 4'hF, 0, 0);
    mech_ctrl_ready = 1'b0;
    repeat (3) @(negedge clk);
    ev(11, 4'h1, 0, 0);
    mech_ctrl_ready = 1'b1;
    foreach (ek[j]) ev(ek[j], ec[j], j < 5, j > 4);
    n = $urandom % 4 + 2;
    host.lines_expected = 16'(n);
    ev(10, 4'hF, 0, 0);
    host.send_lines(n);
    ev(8, 4'hF, 0, 0);
    repeat (3) @(negedge clk);
    check(disp, 6'h08);
    ev(10, 4'hF, 0, 0);
    host.send_lines(n - 1);
    ev(8, 4'hA, 0, 0);
    ev(3, 4'hE, 0, 1);
    ev(10, 4'hF, 0, 0);
    for (i = 1; i < 6; i++) begin
      @(negedge clk);
      host.hit(9);
      @(posedge clk) #1 check(retransmit_req, i < 5);
      @(negedge clk);
      host.clr();
      if (i == 1) q.push_back(6'h0C);
      if (i == 5) q.push_back(6'h0B);
      if (i < 5) host.send_lines(1);
    end
    check(print_held_data, 1);
    @(negedge clk);
    wash_active = 1'b1;
    q.push_back(6'h00);
    repeat (4) @(negedge clk);
    wash_active = 1'b0;
    q.push_back(6'h0B);
    repeat (3) @(negedge clk);
    ev(0, 4'hF, 0, 0);
    q.push_back(6'h0D);
    i = 0;
    while (copy_abort !== 1'b1 && i < 400) begin
      @(posedge clk) #1;
      i++;
    end
    check(i > 295 && i < 310, 1);
    copy_active = 1'b0;
    foreach (ml[j]) begin
      mech_fault = (11'h001 << j) | (11'($urandom) << (j + 1));
      repeat (4) @(negedge clk);
      check(mech_leds, ml[j]);
    end
    mech_fault = 11'h000;
    repeat (4) @(negedge clk);
    check(mech_leds, 5'h1F);
    ev(14, 4'h9, 0, 0);
    repeat (5) @(negedge clk);
    check(fatal_stop, 1);
    check(8'(q.size()), 0);
    give_verdict();
  end
endmodule
`default_nettype wire
